//--- acou_defs.vh
// Register map, reset values and field positions for the alert/crossing output update block
// Assumes an 8-bit register port with 8-bit addresses
`ifndef ACOU_DEFS_VH
`define ACOU_DEFS_VH

`define ACOU_ADDR_OUT5_MASK 8'hcd
`define ACOU_ADDR_OUT6_MASK 8'hcf
`define ACOU_ADDR_OUT7_MASK 8'hd1
`define ACOU_ADDR_XVAL_LO 8'he3
`define ACOU_ADDR_XVAL_HI 8'he4
`define ACOU_ADDR_XING_EN 8'he7
`define ACOU_ADDR_ALERT_EN 8'he9
`define ACOU_ADDR_TRIG_VAL 8'heb

`define ACOU_RST_OUT5_MASK 8'h10
`define ACOU_RST_OUT6_MASK 8'h80
`define ACOU_RST_OUT7_MASK 8'h40
`define ACOU_RST_XVAL_LO 8'h00
`define ACOU_RST_XVAL_HI 8'h00
`define ACOU_RST_XING_EN 8'h00
`define ACOU_RST_ALERT_EN 8'h00
`define ACOU_RST_TRIG_VAL 8'h00

`define ACOU_XVAL_RISE_BIT 1
`define ACOU_XVAL_FALL_BIT 0
`define ACOU_FIRST_MASKED_OUT 5

`endif

//--- acou_alert_edge.v
// Rising-edge detector for one output's combined alert trigger
// Assumes alert flags are synchronous to mclk_i
`timescale 1ns/1ps
module acou_alert_edge (
    input wire mclk_i, // Clock
    input wire resetn_i, // Async reset, active low
    input wire [7:0] alert_flags_i, // Per-channel alert flags
    input wire [7:0] mask_i, // Trigger mask for this output
    output wire fire_o // One-cycle update request
);
    reg any_reg;
    wire any_now;

    assign any_now = |(alert_flags_i & mask_i);

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            any_reg <= 1'b0;
        end else begin
            any_reg <= any_now;
        end
    end

    assign fire_o = any_now & ~any_reg;
endmodule // acou_alert_edge

//--- acou_output_update.v
// Digital output update logic: alert-triggered and zero-crossing-synchronous
// Assumes an 8-bit synchronous register port; alert flags and crossing input on mclk_i
`timescale 1ns/1ps
`include "acou_defs.vh"
module acou_output_update (
    input wire mclk_i, // 20 MHz clock
    input wire resetn_i, // Async reset, active low
    input wire reg_wr_i, // Register write strobe
    input wire reg_rd_i, // Register read strobe
    input wire [7:0] reg_addr_i, // Register address
    input wire [7:0] reg_wdata_i, // Register write data
    output reg [7:0] reg_rdata_o, // Register read data, registered
    input wire [7:0] alert_flags_i, // Per-channel alert flags
    input wire zero_crossing_signal_i, // Crossing detector output
    input wire [7:0] output_trigger_i, // Alert triggers for outputs 0 to 4 from elsewhere
    output reg [7:0] digital_output_o // Digital output levels
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] out5_alert_trigger_mask_reg;
    reg [7:0] out6_alert_trigger_mask_reg;
    reg [7:0] out7_alert_trigger_mask_reg;
    reg [7:0] crossing_value_ch0_to_3_reg;
    reg [7:0] crossing_value_ch4_to_7_reg;
    reg [7:0] crossing_update_enable_reg;
    reg [7:0] alert_update_enable_reg;
    reg [7:0] alert_trigger_value_reg;
    reg zc_prev_reg;
    reg [7:0] out_next;
    reg [7:0] rdata_next;
    wire [15:0] xval_all;
    wire [7:0] fire;
    wire zc_rise;
    wire zc_fall;

    // Level to launch for a field on a given crossing edge
    function xval_level;
        input [1:0] field;
        input rising;
        begin
            xval_level = rising ? field[`ACOU_XVAL_RISE_BIT] : field[`ACOU_XVAL_FALL_BIT];
        end
    endfunction

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out5_alert_trigger_mask_reg <= `ACOU_RST_OUT5_MASK;
            out6_alert_trigger_mask_reg <= `ACOU_RST_OUT6_MASK;
            out7_alert_trigger_mask_reg <= `ACOU_RST_OUT7_MASK;
            crossing_value_ch0_to_3_reg <= `ACOU_RST_XVAL_LO;
            crossing_value_ch4_to_7_reg <= `ACOU_RST_XVAL_HI;
            crossing_update_enable_reg <= `ACOU_RST_XING_EN;
            alert_update_enable_reg <= `ACOU_RST_ALERT_EN;
            alert_trigger_value_reg <= `ACOU_RST_TRIG_VAL;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `ACOU_ADDR_OUT5_MASK: out5_alert_trigger_mask_reg <= reg_wdata_i;
                `ACOU_ADDR_OUT6_MASK: out6_alert_trigger_mask_reg <= reg_wdata_i;
                `ACOU_ADDR_OUT7_MASK: out7_alert_trigger_mask_reg <= reg_wdata_i;
                `ACOU_ADDR_XVAL_LO: crossing_value_ch0_to_3_reg <= reg_wdata_i;
                `ACOU_ADDR_XVAL_HI: crossing_value_ch4_to_7_reg <= reg_wdata_i;
                `ACOU_ADDR_XING_EN: crossing_update_enable_reg <= reg_wdata_i;
                `ACOU_ADDR_ALERT_EN: alert_update_enable_reg <= reg_wdata_i;
                `ACOU_ADDR_TRIG_VAL: alert_trigger_value_reg <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always @* begin
        rdata_next = reg_rdata_o;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ACOU_ADDR_OUT5_MASK: rdata_next = out5_alert_trigger_mask_reg;
                `ACOU_ADDR_OUT6_MASK: rdata_next = out6_alert_trigger_mask_reg;
                `ACOU_ADDR_OUT7_MASK: rdata_next = out7_alert_trigger_mask_reg;
                `ACOU_ADDR_XVAL_LO: rdata_next = crossing_value_ch0_to_3_reg;
                `ACOU_ADDR_XVAL_HI: rdata_next = crossing_value_ch4_to_7_reg;
                `ACOU_ADDR_XING_EN: rdata_next = crossing_update_enable_reg;
                `ACOU_ADDR_ALERT_EN: rdata_next = alert_update_enable_reg;
                `ACOU_ADDR_TRIG_VAL: rdata_next = alert_trigger_value_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Alert trigger detection
    // ------------------------------------------------------------
    assign fire[4:0] = output_trigger_i[4:0];

    acou_alert_edge u_edge5 (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .alert_flags_i(alert_flags_i),
        .mask_i(out5_alert_trigger_mask_reg),
        .fire_o(fire[5])
    );

    acou_alert_edge u_edge6 (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .alert_flags_i(alert_flags_i),
        .mask_i(out6_alert_trigger_mask_reg),
        .fire_o(fire[6])
    );

    acou_alert_edge u_edge7 (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .alert_flags_i(alert_flags_i),
        .mask_i(out7_alert_trigger_mask_reg),
        .fire_o(fire[7])
    );

    // ------------------------------------------------------------
    // Crossing edge detection
    // ------------------------------------------------------------
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            zc_prev_reg <= 1'b0;
        end else begin
            zc_prev_reg <= zero_crossing_signal_i;
        end
    end

    assign zc_rise = zero_crossing_signal_i & ~zc_prev_reg;
    assign zc_fall = ~zero_crossing_signal_i & zc_prev_reg;
    assign xval_all = {crossing_value_ch4_to_7_reg, crossing_value_ch0_to_3_reg};

    // ------------------------------------------------------------
    // Output update; alert update wins over crossing in the same cycle
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_out
            always @* begin
                out_next[g] = digital_output_o[g];
                if (crossing_update_enable_reg[g] && (zc_rise || zc_fall)) begin
                    out_next[g] = xval_level(xval_all[2*g+1:2*g], zc_rise);
                end
                if (alert_update_enable_reg[g] && fire[g]) begin
                    out_next[g] = alert_trigger_value_reg[g];
                end
            end
        end
    endgenerate

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            digital_output_o <= 8'h00;
        end else begin
            digital_output_o <= out_next;
        end
    end
endmodule // acou_output_update

//--- acou_output_update_monitor.sv
// Concurrent checks on the output update block, seen from its ports only
// Assumes the register map header and a single clock with async active-low reset
`timescale 1ns/1ps
`include "acou_defs.vh"
module acou_output_update_monitor (
    input wire mclk_i, // Clock
    input wire resetn_i, // Async reset, active low
    input wire reg_wr_i, // Write strobe
    input wire reg_rd_i, // Read strobe
    input wire [7:0] reg_addr_i, // Address
    input wire [7:0] reg_wdata_i, // Write data
    input wire [7:0] reg_rdata_o, // Read data
    input wire [7:0] alert_flags_i, // Alert flags
    input wire zero_crossing_signal_i, // Crossing level
    input wire [7:0] output_trigger_i, // Triggers for outputs 0 to 4
    input wire [7:0] digital_output_o // Output levels
);
    // ----------------------------------------
    // Shadow registers and edge helpers
    // ----------------------------------------
    reg [7:0] sh [0:255];
    reg [2:0] or_q;
    reg zc_q;
    integer i;
    wire [7:0] aen = sh[`ACOU_ADDR_ALERT_EN];
    wire [7:0] xen = sh[`ACOU_ADDR_XING_EN];
    wire [15:0] xv = {sh[`ACOU_ADDR_XVAL_HI], sh[`ACOU_ADDR_XVAL_LO]};
    wire [7:0] sh_sel = sh[reg_addr_i];
    wire [2:0] or_now = {|(alert_flags_i & sh[`ACOU_ADDR_OUT7_MASK]),
        |(alert_flags_i & sh[`ACOU_ADDR_OUT6_MASK]), |(alert_flags_i & sh[`ACOU_ADDR_OUT5_MASK])};
    wire [7:0] fire = aen & {or_now & ~or_q, output_trigger_i[4:0]};
    wire xedge = zero_crossing_signal_i ^ zc_q;
    wire mapped = (reg_addr_i[7:4] == 4'hc || reg_addr_i == 8'hd1) ? (reg_addr_i == 8'hcd ||
        reg_addr_i == 8'hcf || reg_addr_i == 8'hd1) : (reg_addr_i == 8'he3 || reg_addr_i == 8'he4
        || reg_addr_i == 8'he7 || reg_addr_i == 8'he9 || reg_addr_i == 8'heb);
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (i = 0; i < 256; i = i + 1) sh[i] <= 8'h00;
            sh[`ACOU_ADDR_OUT5_MASK] <= `ACOU_RST_OUT5_MASK;
            sh[`ACOU_ADDR_OUT6_MASK] <= `ACOU_RST_OUT6_MASK;
            sh[`ACOU_ADDR_OUT7_MASK] <= `ACOU_RST_OUT7_MASK;
            or_q <= 3'h0;
            zc_q <= 1'b0;
        end else begin
            if (reg_wr_i) sh[reg_addr_i] <= reg_wdata_i;
            or_q <= or_now;
            zc_q <= zero_crossing_signal_i;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_read_back: assert property (reg_rd_i && mapped |=> reg_rdata_o == $past(sh_sel))
        else $error("register read back wrong");
    genvar n;
    for (n = 0; n < 8; n = n + 1) begin : g_out
        a_alert_update: assert property (
            fire[n] |=> digital_output_o[n] == $past(aen[n] & sh[`ACOU_ADDR_TRIG_VAL][n]))
            else $error("alert update level wrong");
        a_xing_update: assert property (xedge && xen[n] && !fire[n] |=>
            digital_output_o[n] == ($past(zero_crossing_signal_i) ?
            $past(xv[2*n+1]) : $past(xv[2*n])))
            else $error("crossing update level wrong");
        a_out_hold: assert property (!fire[n] && !(xedge && xen[n]) |=>
            $stable(digital_output_o[n])) else $error("output moved without cause");
        a_field_high: assert property (
            xedge && xen[n] && !fire[n] && xv[2*n+1] && xv[2*n] |=>
            digital_output_o[n]) else $error("field 11 not high");
        a_field_low: assert property (
            xedge && xen[n] && !fire[n] && !xv[2*n+1] && !xv[2*n] |=>
            !digital_output_o[n]) else $error("field 00 not low");
    end
endmodule // acou_output_update_monitor
bind acou_output_update acou_output_update_monitor i_mon (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .alert_flags_i(alert_flags_i),
    .zero_crossing_signal_i(zero_crossing_signal_i), .output_trigger_i(output_trigger_i),
    .digital_output_o(digital_output_o));

//--- test_alert_crossing_output_update.sv
// Directed testbench for the output update block
// Assumes the register map header; checker attaches itself by bind
`timescale 1ns/1ps
`include "acou_defs.vh"
`define CHK(g, e) begin n_checks = n_checks + 1; \
    if ((g) !== (e)) begin err_total = err_total + 1; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_alert_crossing_output_update;
    reg mclk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg reg_wr_i = 1'b0;
    reg reg_rd_i = 1'b0;
    reg [7:0] reg_addr_i = 8'h00;
    reg [7:0] reg_wdata_i = 8'h00;
    reg [7:0] alert_flags_i = 8'h00;
    reg zero_crossing_signal_i = 1'b0;
    reg [7:0] output_trigger_i = 8'h00;
    wire [7:0] reg_rdata_o;
    wire [7:0] digital_output_o;
    integer err_total = 0;
    integer n_checks = 0;
    integer cyc = 0;
    always #25 mclk_i = ~mclk_i;
    acou_output_update i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .alert_flags_i(alert_flags_i),
        .zero_crossing_signal_i(zero_crossing_signal_i), .output_trigger_i(output_trigger_i),
        .digital_output_o(digital_output_o));
    // ----------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------
    task wr(input [7:0] a, input [7:0] d);
        begin @(posedge mclk_i); reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge mclk_i); reg_wr_i <= 1'b0; end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin @(posedge mclk_i); reg_rd_i <= 1'b1; reg_addr_i <= a;
        @(posedge mclk_i); reg_rd_i <= 1'b0; @(negedge mclk_i); `CHK(reg_rdata_o, e) end
    endtask
    task drive(input [7:0] fl, input z, input [7:0] tr, input [7:0] e);
        begin @(posedge mclk_i); alert_flags_i <= fl; zero_crossing_signal_i <= z;
        output_trigger_i <= tr; @(posedge mclk_i); output_trigger_i <= 8'h00;
        @(negedge mclk_i); `CHK(digital_output_o, e) end
    endtask
    task end_of_test;
        begin $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish; end
    endtask
    task t_regs;
        begin rd(8'hcd, 8'h10); rd(8'hcf, 8'h80); rd(8'hd1, 8'h40);
        rd(8'he3, 8'h00); rd(8'he4, 8'h00); rd(8'he9, 8'h00);
        rd(8'he7, 8'h00); rd(8'heb, 8'h00);
        wr(8'hce, 8'h55); rd(8'hce, 8'h00);
        wr(8'hcd, 8'h5a); rd(8'hcd, 8'h5a); wr(8'hcd, 8'h10); end
    endtask
    task t_xing;
        begin wr(8'he3, 8'he4); wr(8'he4, 8'he4); wr(8'he7, 8'hff);
        drive(8'h00, 1'b1, 8'h00, 8'hcc);
        drive(8'h00, 1'b0, 8'h00, 8'haa);
        wr(8'he7, 8'h0f); drive(8'h00, 1'b1, 8'h00, 8'hac); end
    endtask
    task t_alert;
        begin wr(8'he7, 8'h00); wr(8'he9, 8'he2); wr(8'heb, 8'h40);
        drive(8'h80, 1'b1, 8'h00, 8'hec);
        wr(8'heb, 8'h00); drive(8'h80, 1'b1, 8'h00, 8'hec);
        drive(8'h90, 1'b1, 8'h00, 8'hcc);
        wr(8'he9, 8'h62); wr(8'hd1, 8'h01); drive(8'h91, 1'b1, 8'h00, 8'hcc);
        wr(8'he9, 8'he2); drive(8'h00, 1'b1, 8'h00, 8'hcc);
        drive(8'h01, 1'b1, 8'h00, 8'h4c);
        wr(8'heb, 8'h02); drive(8'h01, 1'b1, 8'h02, 8'h4e);
        drive(8'h21, 1'b1, 8'h00, 8'h4e); end
    endtask
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin err_total = err_total + 1; end_of_test; end
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        resetn_i <= 1'b1;
        t_regs;
        t_xing;
        t_alert;
        end_of_test;
    end
endmodule // test_alert_crossing_output_update
